// File: hw/adc_port_regs.vh
// Purpose: constants for the converter data-port pin multiplexer
// Assumes: APB with 32-bit data, one aligned word per register
`ifndef ADC_PORT_REGS_VH
`define ADC_PORT_REGS_VH

`define REG_CTRL_OFS      12'h000
`define REG_STATUS_OFS    12'h004
`define REG_WORDS_OFS     12'h008
`define CTRL_ENABLE_BIT   0
`define CTRL_RESET_VAL    32'h0000_0001
`define ST_SERIAL_BIT     0
`define ST_BYTEMODE_BIT   1
`define ST_SELA_BIT       2
`define ST_SELB_BIT       3
`define ST_SELC_BIT       4
`define ST_CHAIN_BIT      5
`define ST_LEVEL_LSB      8
`define PIN_SEL_A         0
`define PIN_SEL_B         1
`define PIN_SEL_C         2
`define PIN_CHAIN_C       3
`define PIN_CHAIN_B       4
`define PIN_CHAIN_A       5
`define PIN_SCLK          6
`define PIN_BIT7          7
`define PIN_DOUT_A        8
`define PIN_DOUT_B        9
`define PIN_DOUT_C        10
`define RESULT_WIDTH      16
`define FIFO_DEPTH        32
`define SYNC_STAGES       2

`endif

// File: hw/sync_two_stage.v
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: inputs are asynchronous to clk_sys
// Notes: first stage is read only by the second
`timescale 1ns/1ns
module sync_two_stage #(
    parameter WIDTH = 1
) (
    input  wire             clk_sys,
    input  wire             reset,
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;

    always @(posedge clk_sys) begin
        if (reset) begin
            stage1_reg <= {WIDTH{1'b0}};
            stage2_reg <= {WIDTH{1'b0}};
        end else begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;
endmodule // sync_two_stage

// File: hw/result_fifo.v
// Purpose: result word buffer between conversion source and port
// Assumes: single clock
// Notes: depth must be a power of two
`timescale 1ns/1ns
module result_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             clk_sys,
    input  wire             reset,
    input  wire [WIDTH-1:0] inData,
    input  wire             inValid,
    output wire             inReady,
    output wire [WIDTH-1:0] outData,
    output wire             outValid,
    input  wire             outReady,
    output wire [AW:0]      level
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wrPtr_reg;
    reg [AW:0]      rdPtr_reg;
    wire            doWrite;
    wire            doRead;

    assign level    = wrPtr_reg - rdPtr_reg;
    assign inReady  = (level != DEPTH[AW:0]);
    assign outValid = (level != {(AW+1){1'b0}});
    assign outData  = mem[rdPtr_reg[AW-1:0]];
    assign doWrite  = inValid & inReady;
    assign doRead   = outValid & outReady;

    always @(posedge clk_sys) begin
        if (doWrite) begin
            mem[wrPtr_reg[AW-1:0]] <= inData;
        end
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            wrPtr_reg <= {(AW+1){1'b0}};
            rdPtr_reg <= {(AW+1){1'b0}};
        end else begin
            if (doWrite) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (doRead) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
        end
    end
endmodule // result_fifo

// File: hw/adc_output_port_pin_config.v
// Purpose: pin-function multiplexer for the converter result port
// Assumes: host drives mode pins and the serial clock; APB on clk_sys
// Notes: pins are split into in, out and active-low output enable
`timescale 1ns/1ns
`include "adc_port_regs.vh"
module adc_output_port_pin_config #(
    parameter WIDTH = `RESULT_WIDTH,
    parameter DEPTH = `FIFO_DEPTH,
    parameter AW    = 5
) (
    input  wire             clk_sys,
    input  wire             reset,
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [11:0]      paddr,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output wire             pready,
    output reg              pslverr,
    input  wire [WIDTH-1:0] resultData,
    input  wire             resultValid,
    output wire             resultReady,
    input  wire             portTypeChoice,
    input  wire             wordByteChoice,
    input  wire             chipSelectN,
    input  wire             readN,
    input  wire [15:0]      parallelBusBitIn,
    output reg  [15:0]      parallelBusBitOut,
    output reg  [15:0]      parallelBusBitOeN
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_LOAD  = 2'h1;
    localparam ST_SHIFT = 2'h2;

    wire [19:0]      pinSync;
    wire [15:0]      busSync;
    wire             serialMode;
    wire             byteMode;
    wire             csActiveN;
    wire             rdActiveN;
    wire             selA;
    wire             selB;
    wire             selC;
    wire             chainModeEnable;
    wire             upperByteFirst;
    wire             chainInA;
    wire             chainInB;
    wire             chainInC;
    wire             sclkLevel;
    wire [WIDTH-1:0] fifoData;
    wire             fifoValid;
    wire [AW:0]      fifoLevel;
    wire             apbAccess;
    wire             enable;

    reg  [31:0]      ctrl_reg;
    reg  [31:0]      words_reg;
    reg  [1:0]       state_reg;
    reg  [1:0]       loadIdx_reg;
    reg  [WIDTH-1:0] shiftA_reg;
    reg  [WIDTH-1:0] shiftB_reg;
    reg  [WIDTH-1:0] shiftC_reg;
    reg              sclkPrev_reg;
    reg              csPrev_reg;
    reg              rdPrev_reg;
    reg              bytePhase_reg;
    reg              pop;
    reg  [15:0]      outNext;
    reg  [15:0]      oeNNext;

    sync_two_stage #(
        .WIDTH(20)
    ) pinSyncInst (
        .clk_sys(clk_sys),
        .reset  (reset),
        // strobes pass inverted so the cleared synchroniser reads as idle after reset
        .asyncIn({portTypeChoice, wordByteChoice, ~chipSelectN, ~readN, parallelBusBitIn}),
        .syncOut(pinSync)
    );

    result_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH),
        .AW   (AW)
    ) fifoInst (
        .clk_sys (clk_sys),
        .reset   (reset),
        .inData  (resultData),
        .inValid (resultValid),
        .inReady (resultReady),
        .outData (fifoData),
        .outValid(fifoValid),
        .outReady(pop),
        .level   (fifoLevel)
    );

    assign busSync         = pinSync[15:0];
    assign rdActiveN       = ~pinSync[16];
    assign csActiveN       = ~pinSync[17];
    assign byteMode        = pinSync[18];
    assign serialMode      = pinSync[19];
    // pin roles follow the synchronised levels directly, no register write needed
    assign selA            = serialMode & busSync[`PIN_SEL_A];
    assign selB            = serialMode & busSync[`PIN_SEL_B];
    assign selC            = serialMode & busSync[`PIN_SEL_C];
    assign chainModeEnable = serialMode & busSync[`PIN_BIT7];
    assign upperByteFirst  = busSync[`PIN_BIT7];
    assign chainInA        = chainModeEnable & busSync[`PIN_CHAIN_A];
    assign chainInB        = chainModeEnable & busSync[`PIN_CHAIN_B];
    assign chainInC        = chainModeEnable & busSync[`PIN_CHAIN_C];
    assign sclkLevel       = busSync[`PIN_SCLK];
    assign enable          = ctrl_reg[`CTRL_ENABLE_BIT];

    // serial frame: cs fall loads line A always and lines B, C only when selected, sclk falls shift
    always @(posedge clk_sys) begin
        if (reset) begin
            state_reg    <= ST_IDLE;
            loadIdx_reg  <= 2'h0;
            shiftA_reg   <= {WIDTH{1'b0}};
            shiftB_reg   <= {WIDTH{1'b0}};
            shiftC_reg   <= {WIDTH{1'b0}};
            sclkPrev_reg <= 1'b0;
            csPrev_reg   <= 1'b1;
            rdPrev_reg   <= 1'b1;
            bytePhase_reg <= 1'b0;
        end else begin
            sclkPrev_reg <= sclkLevel;
            csPrev_reg   <= csActiveN;
            rdPrev_reg   <= rdActiveN;
            case (state_reg)
                ST_IDLE: begin
                    loadIdx_reg <= 2'h0;
                    if (serialMode && enable && csPrev_reg && !csActiveN) begin
                        state_reg <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    // empty buffer shifts zeros rather than stalling the host
                    case (loadIdx_reg)
                        2'h0: shiftA_reg <= fifoValid ? fifoData : {WIDTH{1'b0}};
                        2'h1: shiftB_reg <= (selB && fifoValid) ? fifoData : {WIDTH{1'b0}};
                        default: shiftC_reg <= (selC && fifoValid) ? fifoData : {WIDTH{1'b0}};
                    endcase
                    loadIdx_reg <= loadIdx_reg + 2'h1;
                    if (loadIdx_reg == 2'h2) begin
                        state_reg <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (csActiveN || !serialMode) begin
                        state_reg <= ST_IDLE;
                    end else if (sclkPrev_reg && !sclkLevel) begin
                        // chain inputs enter at the tail so the upstream word follows
                        shiftA_reg <= {shiftA_reg[WIDTH-2:0], chainInA};
                        shiftB_reg <= {shiftB_reg[WIDTH-2:0], chainInB};
                        shiftC_reg <= {shiftC_reg[WIDTH-2:0], chainInC};
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
            if (serialMode || !byteMode || csActiveN) begin
                bytePhase_reg <= 1'b0;
            end else if (!rdPrev_reg && rdActiveN) begin
                bytePhase_reg <= ~bytePhase_reg;
            end
        end
    end

    // buffer pop: serial load slots, or end of a parallel word read
    always @* begin
        pop = 1'b0;
        if (state_reg == ST_LOAD) begin
            case (loadIdx_reg)
                2'h0: pop = 1'b1;
                2'h1: pop = selB;
                default: pop = selC;
            endcase
        end else if (!serialMode && enable && !csActiveN && !rdPrev_reg && rdActiveN) begin
            pop = !byteMode || bytePhase_reg;
        end
    end

    // pin drive; oe low means the pin is driven
    always @* begin
        outNext = 16'h0000;
        oeNNext = 16'hFFFF;
        if (!enable) begin
            oeNNext = 16'hFFFF;
        end else if (serialMode) begin
            // select pins, chain pins, sclk and bit 7 are inputs here
            if (state_reg == ST_SHIFT) begin
                outNext[`PIN_DOUT_A] = shiftA_reg[WIDTH-1];
                outNext[`PIN_DOUT_B] = shiftB_reg[WIDTH-1];
                outNext[`PIN_DOUT_C] = shiftC_reg[WIDTH-1];
            end
            oeNNext[`PIN_DOUT_A] = ~selA;
            oeNNext[`PIN_DOUT_B] = ~selB;
            oeNNext[`PIN_DOUT_C] = ~selC;
        end else if (!csActiveN && !rdActiveN) begin
            if (byteMode) begin
                // byte mode uses the upper lines only; bit 7 stays an input
                if (upperByteFirst ^ bytePhase_reg) begin
                    outNext[15:8] = fifoData[15:8];
                end else begin
                    outNext[15:8] = fifoData[7:0];
                end
                oeNNext[15:8] = 8'h00;
            end else begin
                outNext = fifoData;
                oeNNext = 16'h0000;
            end
        end
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            parallelBusBitOut <= 16'h0000;
            parallelBusBitOeN <= 16'hFFFF;
        end else begin
            parallelBusBitOut <= outNext;
            parallelBusBitOeN <= oeNNext;
        end
    end

    // apb slave: zero wait, error on unmapped word
    assign pready    = 1'b1;
    assign apbAccess = psel & penable;

    always @(posedge clk_sys) begin
        if (reset) begin
            ctrl_reg  <= `CTRL_RESET_VAL;
            words_reg <= 32'h0000_0000;
        end else begin
            if (apbAccess && pwrite && paddr == `REG_CTRL_OFS) begin
                ctrl_reg <= {31'h0000_0000, pwdata[`CTRL_ENABLE_BIT]};
            end
            // a write clears the counter but a pop in the same cycle still counts
            if (pop && fifoValid) begin
                words_reg <= (apbAccess && pwrite && paddr == `REG_WORDS_OFS) ?
                             32'h0000_0001 : words_reg + 32'h0000_0001;
            end else if (apbAccess && pwrite && paddr == `REG_WORDS_OFS) begin
                words_reg <= 32'h0000_0000;
            end
        end
    end

    always @* begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        case (paddr)
            `REG_CTRL_OFS: prdata = ctrl_reg;
            `REG_STATUS_OFS: begin
                prdata[`ST_SERIAL_BIT]   = serialMode;
                prdata[`ST_BYTEMODE_BIT] = byteMode;
                prdata[`ST_SELA_BIT]     = selA;
                prdata[`ST_SELB_BIT]     = selB;
                prdata[`ST_SELC_BIT]     = selC;
                prdata[`ST_CHAIN_BIT]    = chainModeEnable;
                prdata[`ST_LEVEL_LSB+AW:`ST_LEVEL_LSB] = fifoLevel;
            end
            `REG_WORDS_OFS: prdata = words_reg;
            default: pslverr = apbAccess;
        endcase
    end
endmodule // adc_output_port_pin_config

// File: sim/pin_host_model.sv
// Purpose: host side of the converter result port
// Assumes: host drives the mode pins and a 48 ns serial clock
// Notes: released pins toggle every cycle so stale levels never pass
`timescale 1ns/1ns
module pin_host_model (
    input  wire logic [15:0] busOut,
    input  wire logic [15:0] busOeN,
    input  wire logic        clk_sys,
    output wire logic [15:0] busIn,
    output logic             portTypeChoice,
    output logic             wordByteChoice,
    output logic             chipSelectN,
    output logic             readN
);
    logic [15:0] hostDrv = 16'h0000;
    logic [15:0] hostEn  = 16'h0000;
    logic        flip    = 1'b0;
    assign busIn = (~busOeN & busOut) | (busOeN & hostEn & hostDrv)
                 | (busOeN & ~hostEn & {16{flip}});
    always @(posedge clk_sys) flip <= ~flip;
    initial begin
        portTypeChoice = 1'b0;
        wordByteChoice = 1'b0;
        chipSelectN    = 1'b1;
        readN          = 1'b1;
    end
    task automatic setMode(input logic ser, input logic wb, input logic [7:0] low);
        portTypeChoice <= ser;
        wordByteChoice <= wb;
        hostDrv <= {8'h00, ser ? ((low | 8'h41) & (low[7] ? 8'hFF : 8'hC7)) : low};
        hostEn  <= ser ? 16'hF8FF : {8'h00, wb, 7'h00};
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic parRead(input logic wb, output logic [15:0] d1, output logic [15:0] d2);
        chipSelectN <= 1'b0;
        readN       <= 1'b0;
        repeat (8) @(posedge clk_sys);
        d1 = busIn;
        readN <= 1'b1;
        repeat (4) @(posedge clk_sys);
        readN <= !wb;
        repeat (8) @(posedge clk_sys);
        d2 = busIn;
        readN <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chipSelectN <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask
    // clock idles high and runs only inside a frame, offset from clk_sys
    task automatic serFrame(input int n, output logic [31:0] a, b, c);
        chipSelectN <= 1'b0;
        repeat (16) @(posedge clk_sys);
        #1;
        for (int i = 0; i < n; i++) begin
            a = {a[30:0], busIn[8]};
            b = {b[30:0], busIn[9]};
            c = {c[30:0], busIn[10]};
            hostDrv[6] = 1'b0;
            #24;
            hostDrv[6] = 1'b1;
            #24;
        end
        @(posedge clk_sys);
        chipSelectN <= 1'b1;
        repeat (6) @(posedge clk_sys);
    endtask
endmodule // pin_host_model

// File: sim/adc_output_port_pin_config_assertions.sv
// Purpose: pin role checks for the result port multiplexer
// Assumes: pin levels settle within three cycles
// Notes: checks other than a_off wait until the levels have been calm for five cycles
`timescale 1ns/1ns
module adc_port_checker (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        portTypeChoice,
    input wire logic        wordByteChoice,
    input wire logic        chipSelectN,
    input wire logic        readN,
    input wire logic [15:0] parallelBusBitIn,
    input wire logic [15:0] parallelBusBitOeN
);
    logic [2:0] calm;
    logic [6:0] lastIn;
    logic       en;
    wire  [6:0] pinNow = {portTypeChoice, wordByteChoice, chipSelectN, readN,
                          portTypeChoice ? parallelBusBitIn[2:0] : 3'h0};
    wire        ctrlWr = psel && penable && pwrite && paddr == 12'h000;
    wire        ser    = portTypeChoice;
    wire        rdLow  = !ser && !chipSelectN && !readN;
    always @(posedge clk_sys) begin
        lastIn <= pinNow;
        if (reset || pinNow != lastIn || ctrlWr) begin
            calm <= 3'd0;
        end else if (calm != 3'd7) begin
            calm <= calm + 3'd1;
        end
        if (reset) begin
            en <= 1'b1;
        end else if (ctrlWr) begin
            en <= pwdata[0];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_settled; calm >= 3'd5 && pinNow == lastIn && en; endsequence
    sequence s_ctrlOff; ctrlWr && !pwdata[0]; endsequence
    property p_parWord; s_settled ##0 (rdLow && !wordByteChoice)
        |-> parallelBusBitOeN == 16'h0000; endproperty
    property p_parByte; s_settled ##0 (rdLow && wordByteChoice)
        |-> parallelBusBitOeN[15:7] == 9'h001; endproperty
    property p_lineBOff; s_settled ##0 (ser && !parallelBusBitIn[1]) |-> parallelBusBitOeN[9];
    endproperty
    property p_lineCOff; s_settled ##0 (ser && !parallelBusBitIn[2]) |-> parallelBusBitOeN[10];
    endproperty
    property p_lineBLive; s_settled ##0 (ser && parallelBusBitIn[1]) |-> !parallelBusBitOeN[9];
    endproperty
    property p_lineCLive; s_settled ##0 (ser && parallelBusBitIn[2]) |-> !parallelBusBitOeN[10];
    endproperty
    property p_lineALive; s_settled ##0 (ser && parallelBusBitIn[0]) |-> !parallelBusBitOeN[8];
    endproperty
    property p_serInputs; s_settled ##0 ser
        |-> parallelBusBitOeN[7:0] == 8'hFF && parallelBusBitOeN[15:11] == 5'h1F; endproperty
    property p_off; s_ctrlOff |-> ##[1:3] parallelBusBitOeN == 16'hFFFF; endproperty
    a_parWord: assert property (p_parWord) else $error("word read not fully driven");
    a_parByte: assert property (p_parByte) else $error("byte read drive wrong");
    a_lineBOff: assert property (p_lineBOff) else $error("line B driven");
    a_lineCOff: assert property (p_lineCOff) else $error("line C driven");
    a_lineBLive: assert property (p_lineBLive) else $error("line B idle");
    a_lineCLive: assert property (p_lineCLive) else $error("line C idle");
    a_lineALive: assert property (p_lineALive) else $error("line A idle");
    a_serInputs: assert property (p_serInputs) else $error("input pin driven");
    a_off: assert property (p_off) else $error("pins kept after disable");
endmodule // adc_port_checker
bind adc_output_port_pin_config adc_port_checker u_chk (.clk_sys, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .portTypeChoice, .wordByteChoice, .chipSelectN, .readN,
    .parallelBusBitIn, .parallelBusBitOeN);

// File: sim/adc_output_port_pin_config_tb_top.sv
// Purpose: self-checking bench for the result port pin multiplexer
// Assumes: host model drives the pins, bench drives APB and results
// Notes: rows cover parallel reads, serial and APB cases follow by hand
`timescale 1ns/1ns
module adc_output_port_pin_config_tb_top;
    typedef struct {logic wb; logic hb; logic [15:0] data; logic [15:0] e1; logic [7:0] e2;} row_t;
    row_t        rows[4] = '{'{1'b0, 1'b0, 16'hA55A, 16'hA55A, 8'h00},
                             '{1'b0, 1'b1, 16'h0180, 16'h0180, 8'h00},
                             '{1'b1, 1'b1, 16'h12C3, 16'h0012, 8'hC3},
                             '{1'b1, 1'b0, 16'h12C3, 16'h00C3, 8'h12}};
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] resultData = 16'h0000;
    logic        resultValid = 1'b0;
    wire  [31:0] prdata;
    wire         pready, pslverr, resultReady, portTypeChoice, wordByteChoice, chipSelectN, readN;
    wire  [15:0] busIn, busOut, busOeN;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          nAcc;
    logic [31:0] rd, a, b, c;
    logic [15:0] d1, d2;
    logic        err, ok;
    adc_output_port_pin_config dut (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .resultData, .resultValid, .resultReady,
        .portTypeChoice, .wordByteChoice, .chipSelectN, .readN, .parallelBusBitIn(busIn),
        .parallelBusBitOut(busOut), .parallelBusBitOeN(busOeN));
    pin_host_model host (.clk_sys, .busOut, .busOeN, .busIn, .portTypeChoice,
        .wordByteChoice, .chipSelectN, .readN);
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    // a hang costs a mismatch and ends the run
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            $display("unexpected %s: expected %h, seen %h", nm, e, s);
            n_errors++;
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic push(input logic [15:0] d);
        resultData <= d;
        resultValid <= 1'b1;
        @(posedge clk_sys);
        ok = (resultReady === 1'b1);
        resultValid <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        chk("pin enables after reset", 32'hFFFF, {16'h0, busOeN});
        @(posedge clk_sys);
        chk("pin enables second edge after reset", 32'hFFFF, {16'h0, busOeN});
        apb(1'b0, 12'h000, 32'h0);
        chk("control reset value", 32'h1, rd);
        done("reset");
        foreach (rows[i]) begin
            push(rows[i].data);
            host.setMode(1'b0, rows[i].wb, {rows[i].hb, 7'h00});
            host.parRead(rows[i].wb, d1, d2);
            chk("first read", {16'h0, rows[i].e1},
                rows[i].wb ? {24'h0, d1[15:8]} : {16'h0, d1});
            if (rows[i].wb) chk("second byte", {24'h0, rows[i].e2}, {24'h0, d2[15:8]});
            done("parallel row");
        end
        // fill until refused, then drain in order
        host.setMode(1'b0, 1'b0, 8'h00);
        ok = 1'b1;
        nAcc = 0;
        while (ok && nAcc < 40) begin
            push(nAcc[15:0]);
            if (ok) nAcc++;
        end
        chk("words accepted", 32'd32, nAcc);
        apb(1'b0, 12'h004, 32'h0);
        chk("buffer level full", 32'd32, {26'h0, rd[13:8]});
        for (int i = 0; i < 32; i++) begin
            host.parRead(1'b0, d1, d2);
            chk("drained word", i, {16'h0, d1});
        end
        apb(1'b0, 12'h004, 32'h0);
        chk("buffer level empty", 32'd0, {26'h0, rd[13:8]});
        done("buffer");
        push(16'hA5C3);
        push(16'h0F01);
        push(16'h8000);
        host.setMode(1'b1, 1'b0, 8'h07);
        apb(1'b0, 12'h004, 32'h0);
        chk("status flags", 32'h1D, {26'h0, rd[5:0]});
        host.serFrame(16, a, b, c);
        chk("line A word", 32'hA5C3, {16'h0, a[15:0]});
        chk("line B word", 32'h0F01, {16'h0, b[15:0]});
        chk("line C word", 32'h8000, {16'h0, c[15:0]});
        apb(1'b1, 12'h000, 32'h0);
        repeat (4) @(posedge clk_sys);
        chk("pins released when disabled", 32'hFFFF, {16'h0, busOeN});
        apb(1'b1, 12'h000, 32'h1);
        done("serial three lines");
        push(16'h1234);
        host.setMode(1'b1, 1'b0, 8'hA1);
        chk("unselected lines", 32'h3, {30'h0, busOeN[10:9]});
        host.serFrame(32, a, b, c);
        chk("chained line A", 32'h1234FFFF, a);
        // empty buffer loads zeros, so lines B and C show only their chain inputs
        host.setMode(1'b1, 1'b0, 8'hBF);
        host.serFrame(32, a, b, c);
        chk("chained line B", 32'h0000FFFF, b);
        chk("chained line C", 32'h0000FFFF, c);
        done("daisy chain");
        apb(1'b0, 12'h008, 32'h0);
        chk("words popped", 32'd40, rd);
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk("words cleared", 32'd0, rd);
        apb(1'b0, 12'h00C, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        done("apb map");
        finish_test();
    end
endmodule // adc_output_port_pin_config_tb_top
